// file: core/mac_unit_regs.vh
// Register offsets, field positions, reset values and operation codes of the multiply unit
`ifndef MAC_UNIT_REGS_VH
`define MAC_UNIT_REGS_VH

// Byte offsets on the register bus
`define OFS_FIRST_OPERAND   8'h00
`define OFS_SECOND_OPERAND  8'h04
`define OFS_ACCUM_OPERAND   8'h08
`define OFS_RESULT_LOW      8'h0c
`define OFS_RESULT_HIGH     8'h10
`define OFS_CONTROL         8'h14
`define OFS_STATUS_WORD     8'h18
`define OFS_UNIT_STATUS     8'h1c

// Control word fields
`define CTL_OP_LSB          0
`define CTL_OP_MSB          3
`define CTL_X_TOP_BIT       4
`define CTL_Y_TOP_BIT       5
`define CTL_SET_FLAGS_BIT   6
`define CTL_COND_PASS_BIT   7
`define CTL_START_BIT       8

// Program status word fields
`define PSW_N_BIT           31
`define PSW_Z_BIT           30
`define PSW_C_BIT           29
`define PSW_V_BIT           28
`define PSW_Q_BIT           27

// Unit status fields
`define UST_BUSY_BIT        0
`define UST_DONE_BIT        1
`define UST_SKIPPED_BIT     2
`define UST_BAD_OP_BIT      3

// Reset values
`define RST_WORD            32'h00000000
`define RST_CONTROL         9'h000
`define RST_PSW             5'h00

// Operation codes
`define OP_MULTIPLY_LOW                 4'h0
`define OP_MULTIPLY_ADD_LOW             4'h1
`define OP_MULTIPLY_SUBTRACT_LOW        4'h2
`define OP_UNSIGNED_LONG_PRODUCT        4'h3
`define OP_UNSIGNED_DOUBLE_ACCUM_LONG   4'h4
`define OP_UNSIGNED_LONG_ACCUMULATE     4'h5
`define OP_SIGNED_HALFWORD_MAC          4'h6
`define OP_SIGNED_WORD_BY_HALF_MAC      4'h7

`endif

// file: core/mac_datapath.v
// Combinational multiply and accumulate datapath
`timescale 1ns/100ps
`include "mac_unit_regs.vh"

module mac_datapath (
    input  wire [3:0]  op_in,
    input  wire        x_top_in,
    input  wire        y_top_in,
    input  wire [31:0] first_in,
    input  wire [31:0] second_in,
    input  wire [31:0] accum_in,
    input  wire [31:0] low_in,
    input  wire [31:0] high_in,
    output reg  [31:0] res_low_out,
    output reg  [31:0] res_high_out,
    output reg         long_out,
    output reg         sat_out,
    output reg         bad_op_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Unsigned product; its low half is also the two's complement product
    wire        [63:0] product_u    = {32'h00000000, first_in} * {32'h00000000, second_in};
    wire        [31:0] mla_sum      = product_u[31:0] + accum_in;
    wire        [31:0] mls_diff     = accum_in - product_u[31:0];
    wire        [63:0] double_acc   = product_u + {32'h00000000, high_in}
                                    + {32'h00000000, low_in};
    wire        [63:0] long_acc     = product_u + {high_in, low_in};

    ////////////////////////////////////////////////////////////////////////////
    // Halfword selection and signed products
    wire signed [15:0] half_a       = x_top_in ? first_in[31:16]  : first_in[15:0];
    wire signed [15:0] half_b       = y_top_in ? second_in[31:16] : second_in[15:0];
    wire signed [31:0] word_a       = first_in;
    wire signed [31:0] half_prod    = half_a * half_b;
    wire signed [47:0] wide_prod    = word_a * half_b;
    wire        [31:0] half_sum     = half_prod + accum_in;
    wire        [31:0] wide_sum     = wide_prod[47:16] + accum_in;
    // Only the accumulate can overflow; 16x16 signed always fits 32 bits
    wire               half_ovf     = (half_prod[31] == accum_in[31]) &&
                                      (half_sum[31] != accum_in[31]);
    wire               wide_ovf     = (wide_prod[47] == accum_in[31]) &&
                                      (wide_sum[31] != accum_in[31]);

    always @* begin
        res_low_out  = product_u[31:0];
        res_high_out = high_in;
        long_out     = 1'b0;
        sat_out      = 1'b0;
        bad_op_out   = 1'b0;
        case (op_in)
            `OP_MULTIPLY_LOW: begin
                res_low_out = product_u[31:0];
            end
            `OP_MULTIPLY_ADD_LOW: begin
                res_low_out = mla_sum;
            end
            `OP_MULTIPLY_SUBTRACT_LOW: begin
                res_low_out = mls_diff;
            end
            `OP_UNSIGNED_LONG_PRODUCT: begin
                res_low_out  = product_u[31:0];
                res_high_out = product_u[63:32];
                long_out     = 1'b1;
            end
            `OP_UNSIGNED_DOUBLE_ACCUM_LONG: begin
                res_low_out  = double_acc[31:0];
                res_high_out = double_acc[63:32];
                long_out     = 1'b1;
            end
            `OP_UNSIGNED_LONG_ACCUMULATE: begin
                res_low_out  = long_acc[31:0];
                res_high_out = long_acc[63:32];
                long_out     = 1'b1;
            end
            `OP_SIGNED_HALFWORD_MAC: begin
                res_low_out = half_sum;
                sat_out     = half_ovf;
            end
            `OP_SIGNED_WORD_BY_HALF_MAC: begin
                res_low_out = wide_sum;
                sat_out     = wide_ovf;
            end
            default: begin
                bad_op_out = 1'b1;
            end
        endcase
    end

endmodule

// file: core/integer_multiply_accumulate_unit.v
// Multiply and accumulate unit with its register file on an APB slave
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "mac_unit_regs.vh"

module integer_multiply_accumulate_unit (
    input  wire        clock_in,
    input  wire        rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_EXEC   = 3'b010;
    localparam [2:0] ST_COMMIT = 3'b100;

    // Flag positions inside the five-bit status field
    localparam PSW_N = `PSW_N_BIT - `PSW_Q_BIT;
    localparam PSW_Z = `PSW_Z_BIT - `PSW_Q_BIT;
    localparam PSW_Q = `PSW_Q_BIT - `PSW_Q_BIT;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    reg  [31:0] first_operand_reg;
    reg  [31:0] second_operand_reg;
    reg  [31:0] accumulate_operand_reg;
    reg  [31:0] result_low_reg;
    reg  [31:0] result_high_reg;
    reg  [8:0]  control;
    reg  [4:0]  program_status_word;
    reg         done;
    reg         skipped;
    reg         bad_op;
    reg  [2:0]  state;
    reg  [2:0]  next_state;

    // Results held between execute and commit
    reg  [31:0] hold_low;
    reg  [31:0] hold_high;
    reg         hold_long;
    reg         hold_sat;
    reg         hold_bad;

    wire [3:0]  ctl_op        = control[`CTL_OP_MSB:`CTL_OP_LSB];
    wire        ctl_x_top     = control[`CTL_X_TOP_BIT];
    wire        ctl_y_top     = control[`CTL_Y_TOP_BIT];
    wire        ctl_set_flags = control[`CTL_SET_FLAGS_BIT];
    wire        ctl_cond_pass = control[`CTL_COND_PASS_BIT];
    wire        busy          = ~state[0];
    reg  [3:0]  unit_status;

    always @* begin
        unit_status                   = 4'h0;
        unit_status[`UST_BUSY_BIT]    = busy;
        unit_status[`UST_DONE_BIT]    = done;
        unit_status[`UST_SKIPPED_BIT] = skipped;
        unit_status[`UST_BAD_OP_BIT]  = bad_op;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath
    wire [31:0] dp_low;
    wire [31:0] dp_high;
    wire        dp_long;
    wire        dp_sat;
    wire        dp_bad;

    mac_datapath u_datapath (
        .op_in        (ctl_op),
        .x_top_in     (ctl_x_top),
        .y_top_in     (ctl_y_top),
        .first_in     (first_operand_reg),
        .second_in    (second_operand_reg),
        .accum_in     (accumulate_operand_reg),
        .low_in       (result_low_reg),
        .high_in      (result_high_reg),
        .res_low_out  (dp_low),
        .res_high_out (dp_high),
        .long_out     (dp_long),
        .sat_out      (dp_sat),
        .bad_op_out   (dp_bad)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    // One wait state: pready rises in the second access cycle, so read data
    // and the error answer can both come from flip-flops.
    wire        access     = psel_in & penable_in;
    wire        completing = access & pready_out;
    reg         addr_hit;
    reg  [31:0] read_word;

    always @* begin
        addr_hit  = 1'b1;
        read_word = 32'h00000000;
        case (paddr_in)
            `OFS_FIRST_OPERAND: begin
                read_word = first_operand_reg;
            end
            `OFS_SECOND_OPERAND: begin
                read_word = second_operand_reg;
            end
            `OFS_ACCUM_OPERAND: begin
                read_word = accumulate_operand_reg;
            end
            `OFS_RESULT_LOW: begin
                read_word = result_low_reg;
            end
            `OFS_RESULT_HIGH: begin
                read_word = result_high_reg;
            end
            `OFS_CONTROL: begin
                read_word = {23'h000000, control};
            end
            `OFS_STATUS_WORD: begin
                read_word = {program_status_word, 27'h0000000};
            end
            `OFS_UNIT_STATUS: begin
                read_word = {28'h0000000, unit_status};
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Writes are refused while an operation runs so operands cannot tear
    wire        write_err = pwrite_in & busy;
    wire        bad_xfer  = ~addr_hit | write_err;
    // The refusal is settled in the first access cycle; the write obeys that
    // same answer, so an error reply never comes with a landed write
    wire        do_write  = completing & pwrite_in & ~pslverr_out;
    wire        start     = do_write & (paddr_in == `OFS_CONTROL) &
                            pwdata_in[`CTL_START_BIT];
    wire        first_acc = access & ~pready_out;
    reg         next_pready;
    reg         next_pslverr;
    reg  [31:0] next_prdata;

    always @* begin
        next_pready  = first_acc;
        next_pslverr = first_acc & bad_xfer;
        next_prdata  = `RST_WORD;
        if (first_acc & ~pwrite_in & addr_hit) begin
            next_prdata = read_word;
        end
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= `RST_WORD;
        end else begin
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
            prdata_out  <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_COMMIT;
            end
            ST_COMMIT: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            state     <= ST_IDLE;
            hold_low  <= `RST_WORD;
            hold_high <= `RST_WORD;
            hold_long <= 1'b0;
            hold_sat  <= 1'b0;
            hold_bad  <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_EXEC) begin
                hold_low  <= dp_low;
                hold_high <= dp_high;
                hold_long <= dp_long;
                hold_sat  <= dp_sat;
                hold_bad  <= dp_bad;
            end
        end
    end

    wire commit    = (state == ST_COMMIT);
    wire write_res = commit & ctl_cond_pass & ~hold_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Operand and result registers
    always @(posedge clock_in) begin
        if (rst_in) begin
            first_operand_reg      <= `RST_WORD;
            second_operand_reg     <= `RST_WORD;
            accumulate_operand_reg <= `RST_WORD;
            result_low_reg         <= `RST_WORD;
            result_high_reg        <= `RST_WORD;
            control                <= `RST_CONTROL;
        end else begin
            if (do_write) begin
                case (paddr_in)
                    `OFS_FIRST_OPERAND: begin
                        first_operand_reg <= pwdata_in;
                    end
                    `OFS_SECOND_OPERAND: begin
                        second_operand_reg <= pwdata_in;
                    end
                    `OFS_ACCUM_OPERAND: begin
                        accumulate_operand_reg <= pwdata_in;
                    end
                    `OFS_RESULT_LOW: begin
                        result_low_reg <= pwdata_in;
                    end
                    `OFS_RESULT_HIGH: begin
                        result_high_reg <= pwdata_in;
                    end
                    `OFS_CONTROL: begin
                        // Start is a strobe and never reads back as set
                        control <= {1'b0, pwdata_in[`CTL_COND_PASS_BIT:`CTL_OP_LSB]};
                    end
                    default: begin
                        control <= control;
                    end
                endcase
            end
            if (write_res) begin
                // 32-bit results land in the low register only
                result_low_reg <= hold_low;
                if (hold_long) begin
                    result_high_reg <= hold_high;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program status word
    wire        flag_mul   = write_res & (ctl_op == `OP_MULTIPLY_LOW) & ctl_set_flags;
    wire        sat_set    = write_res & hold_sat;
    wire        psw_write  = do_write & (paddr_in == `OFS_STATUS_WORD);
    reg  [4:0]  next_psw;

    // Flag events come last so they win over a software write
    always @* begin
        next_psw = program_status_word;
        if (psw_write) begin
            next_psw = pwdata_in[`PSW_N_BIT:`PSW_Q_BIT];
        end
        if (flag_mul) begin
            // Carry and overflow are left alone
            next_psw[PSW_N] = hold_low[31];
            next_psw[PSW_Z] = (hold_low == 32'h00000000);
        end
        // No path here clears Q; only software may
        if (sat_set) begin
            next_psw[PSW_Q] = 1'b1;
        end
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            program_status_word <= `RST_PSW;
        end else begin
            program_status_word <= next_psw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Unit status
    reg         next_done;
    reg         next_skipped;
    reg         next_bad_op;

    // A start clears the previous verdict; commit posts the new one
    always @* begin
        next_done    = done;
        next_skipped = skipped;
        next_bad_op  = bad_op;
        if (start) begin
            next_done    = 1'b0;
            next_skipped = 1'b0;
            next_bad_op  = 1'b0;
        end else if (commit) begin
            next_done    = 1'b1;
            next_skipped = ~ctl_cond_pass;
            next_bad_op  = hold_bad;
        end
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            done    <= 1'b0;
            skipped <= 1'b0;
            bad_op  <= 1'b0;
        end else begin
            done    <= next_done;
            skipped <= next_skipped;
            bad_op  <= next_bad_op;
        end
    end

endmodule

// file: tb/mac_unit_sva.sv
// Bus timing and refusal checks for the multiply unit
`timescale 1ns/100ps
module mac_unit_sva (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence access_s;
        psel_in && penable_in;
    endsequence
    sequence bad_setup_s;
        psel_in && !penable_in && (paddr_in > 8'h1c);
    endsequence
    sequence good_read_s;
        psel_in && !penable_in && !pwrite_in && (paddr_in <= 8'h1c) && (paddr_in[1:0] == 2'b00);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_one_wait: assert property (setup_s ##1 access_s |-> !pready_out ##1 pready_out)
        else $error("ready not one cycle after first access cycle");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    chk_err_qualified: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_rdata_quiet: assert property (!pready_out |-> prdata_out == 32'h00000000)
        else $error("read data not zero outside ready");
    chk_ready_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside an access phase");
    chk_unmapped_err: assert property (bad_setup_s ##1 access_s |=> pslverr_out)
        else $error("unmapped address not refused");
    chk_unmapped_zero: assert property (bad_setup_s ##1 access_s |=> prdata_out == 32'h00000000)
        else $error("unmapped read returned data");
    chk_mapped_read: assert property (good_read_s ##1 access_s |=> pready_out && !pslverr_out)
        else $error("mapped read refused");
endmodule

// file: tb/decoder_bus_model.sv
// Bus-side model of the instruction decoder and register file
`timescale 1ns/100ps
module decoder_bus_model (
    input  wire logic        clock_in,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [7:0]       paddr_out,
    output logic [31:0]      pwdata_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h00000000;
    end
    // Operands sit in fixed slots, never stack pointer or program counter
    // High and low results are always two separate slots
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clock_in);
        psel_out <= 1'b1;
        pwrite_out <= wr;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clock_in);
        penable_out <= 1'b1;
        // Only the bench watchdog ends a wait that never gets an answer
        do begin
            @(posedge clock_in);
        end while (pready_in !== 1'b1);
        q = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Released data must not look like the last word
        pwdata_out <= ~d;
    endtask
endmodule

// file: tb/test_integer_multiply_accumulate_unit.sv
// Self-checking bench for the multiply unit
`timescale 1ns/100ps
`include "mac_unit_regs.vh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_integer_multiply_accumulate_unit;
    logic        clock_in;
    logic        rst_in;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        er;
    int          err_total = 0;
    int          num_checks = 0;

    decoder_bus_model bus (.clock_in(clock_in), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata));
    integer_multiply_accumulate_unit dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("Totals: %0d mismatches in %0d checks", err_total, num_checks);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.xfer(1'b1, a, d, rd, er);
        `CHK(er, 1'b0)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus.xfer(1'b0, a, 32'h0, rd, er);
        `CHK({er, rd}, {1'b0, exp})
    endtask
    function automatic logic [31:0] hsel(input logic [31:0] v, input logic t);
        return t ? {{16{v[31]}}, v[31:16]} : {{16{v[15]}}, v[15:0]};
    endfunction
    // Loads operands, starts, then polls until idle or ten reads; status stays in rd
    task automatic exec(input logic [7:0] ctl, input logic [31:0] a, b, c, lo, hi, psw);
        int n;
        wr(`OFS_FIRST_OPERAND, a);
        wr(`OFS_SECOND_OPERAND, b);
        wr(`OFS_ACCUM_OPERAND, c);
        wr(`OFS_RESULT_LOW, lo);
        wr(`OFS_RESULT_HIGH, hi);
        wr(`OFS_STATUS_WORD, psw);
        wr(`OFS_CONTROL, {23'h0, 1'b1, ctl});
        n = 0;
        rd = 32'h1;
        while (rd[`UST_BUSY_BIT] !== 1'b0 && n < 10) begin
            bus.xfer(1'b0, `OFS_UNIT_STATUS, 32'h0, rd, er);
            n++;
        end
        `CHK(rd[`UST_BUSY_BIT], 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_low32;
        logic [31:0] a, b, c, p;
        a = 32'hfffffffe;
        b = 32'h00000003;
        c = 32'h00000010;
        p = a * b;
        for (logic [3:0] op = 0; op < 3; op++) begin
            exec({4'h8, op}, a, b, c, 32'h0, 32'h0, 32'h0);
            rdchk(`OFS_RESULT_LOW, op == 0 ? p : (op == 1 ? p + c : c - p));
        end
    endtask
    task automatic t_flags;
        // Flag-setting multiply only issued unconditionally
        exec(8'hc0, 32'h00010000, 32'h00010000, 32'h0, 32'h0, 32'h0, 32'h30000000);
        rdchk(`OFS_STATUS_WORD, 32'h70000000);
        exec(8'hc0, 32'hffffffff, 32'h00000005, 32'h0, 32'h0, 32'h0, 32'h30000000);
        rdchk(`OFS_RESULT_LOW, 32'hfffffffb);
        rdchk(`OFS_STATUS_WORD, 32'hb0000000);
    endtask
    task automatic t_long;
        logic [63:0] p;
        p = 64'hffffffff * 64'hffffffff;
        exec(8'hc3, 32'hffffffff, 32'hffffffff, 32'h0, 32'h5, 32'h6, 32'hf8000000);
        rdchk(`OFS_RESULT_LOW, p[31:0]);
        rdchk(`OFS_RESULT_HIGH, p[63:32]);
        rdchk(`OFS_STATUS_WORD, 32'hf8000000);
        p = p + 64'hffffffff + 64'hffffffff;
        exec(8'h84, 32'hffffffff, 32'hffffffff, 32'h0, 32'hffffffff, 32'hffffffff, 32'h0);
        rdchk(`OFS_RESULT_LOW, p[31:0]);
        rdchk(`OFS_RESULT_HIGH, p[63:32]);
        p = 64'h3 * 64'h7 + 64'h00000001_ffffffff;
        exec(8'hc5, 32'h3, 32'h7, 32'h0, 32'hffffffff, 32'h1, 32'hf8000000);
        rdchk(`OFS_RESULT_LOW, p[31:0]);
        rdchk(`OFS_RESULT_HIGH, p[63:32]);
        rdchk(`OFS_STATUS_WORD, 32'hf8000000);
    endtask
    task automatic t_half;
        logic [31:0] a, b, c;
        a = 32'h80000003;
        b = 32'h0007fffe;
        c = 32'h00000100;
        for (logic [2:0] s = 0; s < 4; s++) begin
            exec({2'b10, s[1], s[0], 4'h6}, a, b, c, 32'h0, 32'h0, 32'h0);
            rdchk(`OFS_RESULT_LOW, hsel(a, s[0]) * hsel(b, s[1]) + c);
            rdchk(`OFS_STATUS_WORD, 32'h0);
        end
    endtask
    task automatic t_sat;
        logic [63:0] w;
        exec(8'h86, 32'h1, 32'h1, 32'h7fffffff, 32'h0, 32'h0, 32'h0);
        rdchk(`OFS_RESULT_LOW, 32'h80000000);
        rdchk(`OFS_STATUS_WORD, 32'h08000000);
        exec(8'h86, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h08000000);
        rdchk(`OFS_STATUS_WORD, 32'h08000000);
        w = 64'h00000000_00030000 * 64'hffffffff_fffffffe;
        exec(8'h87, 32'h00030000, 32'h0000fffe, 32'h80000000, 32'h0, 32'h0, 32'h0);
        rdchk(`OFS_RESULT_LOW, w[47:16] + 32'h80000000);
        rdchk(`OFS_STATUS_WORD, 32'h08000000);
        w = 64'h12345678 * 64'h4000;
        exec(8'ha7, 32'h12345678, 32'h40000000, 32'h1, 32'h0, 32'h0, 32'h0);
        rdchk(`OFS_RESULT_LOW, w[47:16] + 32'h1);
        rdchk(`OFS_STATUS_WORD, 32'h0);
    endtask
    task automatic t_skip;
        exec(8'h40, 32'h2, 32'h3, 32'h0, 32'h0000abcd, 32'h00001234, 32'h30000000);
        `CHK(rd[`UST_SKIPPED_BIT], 1'b1)
        rdchk(`OFS_RESULT_LOW, 32'h0000abcd);
        rdchk(`OFS_RESULT_HIGH, 32'h00001234);
        rdchk(`OFS_STATUS_WORD, 32'h30000000);
    endtask
    task automatic t_bus;
        // Runs first, so these see the reset values
        rdchk(`OFS_UNIT_STATUS, 32'h00000000);
        rdchk(`OFS_RESULT_LOW, 32'h00000000);
        bus.xfer(1'b0, 8'h20, 32'h0, rd, er);
        `CHK({er, rd}, 33'h100000000)
        bus.xfer(1'b1, 8'h24, 32'h5a5a5a5a, rd, er);
        `CHK(er, 1'b1)
        exec(8'h88, 32'h2, 32'h3, 32'h0, 32'h00000077, 32'h0, 32'h0);
        `CHK(rd[`UST_BAD_OP_BIT], 1'b1)
        rdchk(`OFS_RESULT_LOW, 32'h00000077);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        err_total++;
        $display("Watchdog expired");
        test_done();
    end
    initial begin
        rst_in = 1'b1;
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        t_bus();
        t_low32();
        t_flags();
        t_long();
        t_half();
        t_sat();
        t_skip();
        test_done();
    end
endmodule

bind integer_multiply_accumulate_unit mac_unit_sva chk (.clock_in(clock_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out));
